// ### rtl/flash_seq_pkg.sv
// Shared constants, types and command carriers of the flash page programming sequencer.
package flash_seq_pkg;

    // ------------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] FLASH_CONTROL_REG_ADDR = 8'hd1;  // Control register.
    localparam logic [7:0] FLASH_STATUS_REG_ADDR  = 8'hd3;  // Status register.
    localparam logic [7:0] AUX_CONTROL_REG_ADDR   = 8'ha2;  // Auxiliary control register.
    localparam int         KEY_MSB                = 7;      // Launch key nibble, top bit.
    localparam int         KEY_LSB                = 4;      // Launch key nibble, low bit.
    localparam int         LATCH_MAP_BIT          = 3;      // Latch space map bit.
    localparam int         TARGET_MSB             = 2;      // Target select, top bit.
    localparam int         TARGET_LSB             = 1;      // Target select, low bit.
    localparam int         BUSY_BIT               = 0;      // Program in progress bit.
    localparam int         FAULT_BIT              = 1;      // Sequence fault bit.
    localparam int         LOADED_BIT             = 0;      // Latch loaded bit.
    localparam int         BOOT_MAP_BIT           = 5;      // Boot area map bit.
    localparam logic [7:0] CONTROL_RESET          = 8'h00;  // Control value after reset.

    // ------------------------------------------------------------------
    // Key values and address windows
    // ------------------------------------------------------------------
    localparam logic [3:0]  KEY_ARM        = 4'h5;     // Arming nibble.
    localparam logic [3:0]  KEY_LAUNCH     = 4'ha;     // Launch nibble.
    localparam logic [15:0] XROW_BASE      = 16'hff80; // First extra row address.
    localparam logic [15:0] BOOT_BASE      = 16'hf800; // First boot array address.
    localparam logic [15:0] FUSE_ADDR      = 16'h0000; // Security fuse byte address.
    localparam int          LAUNCH_CYCLES  = 2;        // Launch write to operation start.

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Target space select field encoding.
    typedef enum logic [1:0] {
        TGT_USER  = 2'h0,
        TGT_XROW  = 2'h1,
        TGT_FUSE  = 2'h2,
        TGT_CLEAR = 2'h3
    } target_e;

    // Flash array operation.
    typedef enum logic {
        OP_ERASE,
        OP_PROGRAM
    } flash_op_e;

    // Source that answers a code-space read.
    typedef enum logic [1:0] {
        SRC_USER,
        SRC_BOOT,
        SRC_XROW,
        SRC_FUSE
    } code_src_e;

    // One byte operation handed to the flash array.
    typedef struct packed {
        flash_op_e   op;
        target_e     space;
        logic [15:0] addr;
        logic [7:0]  data;
    } flash_cmd_s;

    // One external data write from the core.
    typedef struct packed {
        logic        pointer_register_form;
        logic [15:0] addr;
        logic [7:0]  data;
    } xdata_wr_s;

endpackage

// ### rtl/flash_page_program_sequencer.sv
// Flash page programming sequencer: key unlock, column latches, erase and program walk.
//
// Contract
// - Key 5 arms, then A launches.
// - 50h,A0h from boot array programs user array.
// - 52h,A2h writes latches into extra row.
// - 56h,A6h clears latches, programs nothing.
// - Instruction between arm and launch blocks programming.
// - Busy flag set during cycle, software read-only.
// - Operation begins second machine cycle after launch.
// - Boot map bit overlays boot array F800h-FFFFh.
// - Latches take 1-128 bytes, any order.
// - Last load's page address selects target page.
// - Erase then program only loaded positions.
// - Launch with empty latches sets fault, except the clear option.
// - Latch loads ignored while write in progress.
// - Successful write clears latches and markers.
// - Arming write not followed by launch faults.
// - Fault cleared by software zero or success.
// - Control 02h maps extra row at FF80h-FFFFh.
// - Control 04h maps fuse byte at 0000h.
// - Loaded flag sets on first load, clears on success.
// - Latch map redirects pointer-register external data writes to latches.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module flash_page_program_sequencer #(
    parameter int PAGE_BYTES = 128  // Column latch page size in bytes.
) (
    // Clock and reset.
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Register port.
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    // Core status.
    input  wire logic                       instr_end,
    input  wire logic                       exec_from_boot,
    // External data writes from the core.
    input  wire logic                       xwr,
    input  wire flash_seq_pkg::xdata_wr_s   xwr_req,
    output logic                            xmem_wr,
    // Code-space read steering.
    input  wire logic [15:0]                code_addr,
    output flash_seq_pkg::code_src_e        code_src,
    // Flash array command port.
    output logic                            flash_req,
    output flash_seq_pkg::flash_cmd_s       flash_cmd,
    input  wire logic                       flash_done
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    localparam int IDX_W = $clog2(PAGE_BYTES);

    // The page offset must be a whole number of address bits.
    initial begin
        if (PAGE_BYTES < 2 || PAGE_BYTES > 256 || (1 << IDX_W) != PAGE_BYTES) begin
            $error("PAGE_BYTES must be a power of two from 2 to 256.");
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_ERASE,
        ST_PROG
    } seq_e;

    seq_e                        state_ff;        // Sequencer state.
    logic [1:0]                  delay_ff;        // Launch delay counter.
    logic                        latch_map_ff;    // Latch space map bit.
    flash_seq_pkg::target_e      target_ff;       // Target select field.
    flash_seq_pkg::target_e      run_target_ff;   // Target captured at launch.
    logic                        boot_map_ff;     // Boot area map bit.
    logic                        armed_ff;        // Arming write seen.
    logic                        arm_ended_ff;    // Arming instruction has finished.
    logic                        fault_ff;        // Sequence fault flag.
    logic                        loaded_ff;       // Latch loaded flag.
    logic [PAGE_BYTES-1:0]       mask_ff;         // Per-byte loaded markers.
    logic [7:0]                  latch_mem [PAGE_BYTES];  // Column latch data.
    logic [15-IDX_W:0]           page_ff;         // Page of the last latch load.
    logic [IDX_W-1:0]            idx_ff;          // Byte walk position.
    logic                        req_ff;          // Flash request outstanding.
    flash_seq_pkg::flash_cmd_s   cmd_ff;          // Flash command in flight.
    logic [7:0]                  rdata_ff;        // Registered read data.

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic                   ctl_wr;       // Control register write.
    logic [3:0]             wr_key;       // Key nibble of this write.
    logic                   arm_wr;       // Arming write.
    logic                   launch_ok;    // Accepted launch write.
    logic                   busy;         // Program in progress.
    logic                   latch_wr;     // Write that lands in the latches.
    logic                   stray_instr;  // Instruction ran between arm and launch.
    flash_seq_pkg::target_e wr_target;    // Target select of this write.
    logic                   walk_last;    // Walk is at the last byte.
    logic                   step;         // Walk moves to the next byte.

    assign ctl_wr    = reg_wr && reg_addr == flash_seq_pkg::FLASH_CONTROL_REG_ADDR;
    assign wr_key    = reg_wdata[flash_seq_pkg::KEY_MSB:flash_seq_pkg::KEY_LSB];
    assign wr_target = flash_seq_pkg::target_e'(
                           reg_wdata[flash_seq_pkg::TARGET_MSB:flash_seq_pkg::TARGET_LSB]);
    assign arm_wr    = ctl_wr && wr_key == flash_seq_pkg::KEY_ARM;
    // Launch needs an unbroken arm, boot-array execution and an idle sequencer.
    assign launch_ok = ctl_wr && wr_key == flash_seq_pkg::KEY_LAUNCH && armed_ff
                       && exec_from_boot && state_ff == ST_IDLE;
    assign stray_instr = armed_ff && arm_ended_ff && instr_end && !ctl_wr;
    assign busy      = state_ff == ST_ERASE || state_ff == ST_PROG;
    // Only pointer-register writes with the latch map set reach the latches.
    assign latch_wr  = xwr && latch_map_ff && xwr_req.pointer_register_form;
    assign xmem_wr   = xwr && !latch_wr;
    assign walk_last = idx_ff == IDX_W'(PAGE_BYTES - 1);
    // Unloaded positions are skipped in one cycle; loaded ones wait for the array.
    assign step      = (!req_ff && !mask_ff[idx_ff]) || (req_ff && flash_done);

    // ------------------------------------------------------------------
    // Control and auxiliary registers
    // ------------------------------------------------------------------
    // Map and target fields follow every control write; busy is not writable.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_map_ff <= flash_seq_pkg::CONTROL_RESET[flash_seq_pkg::LATCH_MAP_BIT];
            target_ff    <= flash_seq_pkg::TGT_USER;
            boot_map_ff  <= 1'b0;
        end else begin
            if (ctl_wr) begin
                latch_map_ff <= reg_wdata[flash_seq_pkg::LATCH_MAP_BIT];
                target_ff    <= wr_target;
            end
            if (reg_wr && reg_addr == flash_seq_pkg::AUX_CONTROL_REG_ADDR) begin
                boot_map_ff <= reg_wdata[flash_seq_pkg::BOOT_MAP_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Key sequence
    // ------------------------------------------------------------------
    // Arms on 5, disarms on any other control write or a stray instruction.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            armed_ff     <= 1'b0;
            arm_ended_ff <= 1'b0;
        end else if (arm_wr) begin
            armed_ff     <= 1'b1;
            arm_ended_ff <= 1'b0;
        end else if (ctl_wr || stray_instr) begin
            armed_ff     <= 1'b0;
            arm_ended_ff <= 1'b0;
        end else if (armed_ff && instr_end) begin
            arm_ended_ff <= 1'b1;  // The arming instruction itself has finished.
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // Fault: set beats the software clear; success clears it.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_ff <= 1'b0;
        end else if ((armed_ff && (ctl_wr && !launch_ok && wr_key != flash_seq_pkg::KEY_LAUNCH
                     || stray_instr))
                     || (launch_ok && target_ff != flash_seq_pkg::TGT_CLEAR
                         && mask_ff == '0)) begin
            fault_ff <= 1'b1;
        end else if (state_ff == ST_DELAY && run_target_ff == flash_seq_pkg::TGT_CLEAR
                     || state_ff == ST_PROG && walk_last && step) begin
            fault_ff <= 1'b0;
        end else if (reg_wr && reg_addr == flash_seq_pkg::FLASH_STATUS_REG_ADDR
                     && !reg_wdata[flash_seq_pkg::FAULT_BIT]) begin
            fault_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Column latches
    // ------------------------------------------------------------------
    // Latch data has no reset; the markers say which bytes are valid.
    always_ff @(posedge clk) begin
        if (latch_wr && state_ff == ST_IDLE) begin
            latch_mem[xwr_req.addr[IDX_W-1:0]] <= xwr_req.data;
        end
    end

    // Markers, page and loaded flag; loads are ignored once a launch is taken.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_ff   <= '0;
            page_ff   <= '0;
            loaded_ff <= 1'b0;
        end else if (state_ff == ST_DELAY && run_target_ff == flash_seq_pkg::TGT_CLEAR
                     || state_ff == ST_PROG && walk_last && step) begin
            mask_ff   <= '0;
            loaded_ff <= 1'b0;
        end else if (latch_wr && state_ff == ST_IDLE) begin
            mask_ff[xwr_req.addr[IDX_W-1:0]] <= 1'b1;
            page_ff   <= xwr_req.addr[15:IDX_W];
            loaded_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Launch, wait, erase loaded bytes, program loaded bytes, finish.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff      <= ST_IDLE;
            delay_ff      <= '0;
            run_target_ff <= flash_seq_pkg::TGT_USER;
            idx_ff        <= '0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    idx_ff <= '0;
                    if (launch_ok && (target_ff == flash_seq_pkg::TGT_CLEAR
                                      || mask_ff != '0)) begin
                        state_ff      <= ST_DELAY;
                        delay_ff      <= 2'(flash_seq_pkg::LAUNCH_CYCLES - 1);
                        run_target_ff <= target_ff;
                    end
                end
                ST_DELAY: begin
                    // The clear option finishes here without touching the array.
                    if (run_target_ff == flash_seq_pkg::TGT_CLEAR) begin
                        state_ff <= ST_IDLE;
                    end else if (delay_ff == 2'h1) begin
                        state_ff <= ST_ERASE;
                    end else begin
                        delay_ff <= delay_ff - 2'h1;
                    end
                end
                ST_ERASE: begin
                    if (step) begin
                        idx_ff <= idx_ff + 1'b1;
                        if (walk_last) begin
                            state_ff <= ST_PROG;
                        end
                    end
                end
                ST_PROG: begin
                    if (step) begin
                        idx_ff <= idx_ff + 1'b1;
                        if (walk_last) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Flash command issue
    // ------------------------------------------------------------------
    // One request per loaded byte in each of the erase and program walks, held until the array reports done.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_ff <= 1'b0;
            cmd_ff <= '0;
        end else if (req_ff) begin
            if (flash_done) begin
                req_ff <= 1'b0;
            end
        end else if (busy && mask_ff[idx_ff]) begin
            req_ff       <= 1'b1;
            cmd_ff.op    <= state_ff == ST_ERASE ? flash_seq_pkg::OP_ERASE
                                                 : flash_seq_pkg::OP_PROGRAM;
            cmd_ff.space <= run_target_ff;
            cmd_ff.data  <= latch_mem[idx_ff];
            unique case (run_target_ff)
                flash_seq_pkg::TGT_XROW: cmd_ff.addr <= flash_seq_pkg::XROW_BASE
                                                        | 16'(idx_ff);
                flash_seq_pkg::TGT_FUSE: cmd_ff.addr <= flash_seq_pkg::FUSE_ADDR;
                default:                 cmd_ff.addr <= {page_ff, idx_ff};
            endcase
        end
    end

    assign flash_req = req_ff;
    assign flash_cmd = cmd_ff;

    // ------------------------------------------------------------------
    // Code-space read steering
    // ------------------------------------------------------------------
    // Boot overlay first, then the extra row and fuse maps.
    always_comb begin
        if (boot_map_ff && code_addr >= flash_seq_pkg::BOOT_BASE) begin
            code_src = flash_seq_pkg::SRC_BOOT;
        end else if (target_ff == flash_seq_pkg::TGT_XROW
                     && code_addr >= flash_seq_pkg::XROW_BASE) begin
            code_src = flash_seq_pkg::SRC_XROW;
        end else if (target_ff == flash_seq_pkg::TGT_FUSE
                     && code_addr == flash_seq_pkg::FUSE_ADDR) begin
            code_src = flash_seq_pkg::SRC_FUSE;
        end else begin
            code_src = flash_seq_pkg::SRC_USER;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Key nibble reads as zero; unmapped addresses read zero.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                flash_seq_pkg::FLASH_CONTROL_REG_ADDR:
                    rdata_ff <= {4'h0, latch_map_ff, target_ff, busy};
                flash_seq_pkg::FLASH_STATUS_REG_ADDR:
                    rdata_ff <= {6'h00, fault_ff, loaded_ff};
                flash_seq_pkg::AUX_CONTROL_REG_ADDR:
                    rdata_ff <= 8'(boot_map_ff) << flash_seq_pkg::BOOT_MAP_BIT;
                default:
                    rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_prog_launch;
        launch_ok && target_ff != flash_seq_pkg::TGT_CLEAR && mask_ff != '0;
    endsequence

    property p_arm_only;
        arm_wr && state_ff == ST_IDLE |=> state_ff == ST_IDLE && armed_ff;
    endproperty
    a_arm_only: assert property (p_arm_only) else $error("Arming write acted.");

    property p_start_delay;
        s_prog_launch |-> ##1 !busy ##1 busy;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("Bad start delay.");

    property p_empty_fault;
        launch_ok && target_ff != flash_seq_pkg::TGT_CLEAR && mask_ff == '0
            |=> fault_ff && state_ff == ST_IDLE;
    endproperty
    a_empty_fault: assert property (p_empty_fault) else $error("Empty launch.");

    property p_busy_hold;
        state_ff != ST_IDLE && latch_wr
            |=> $stable(page_ff) && (mask_ff & ~$past(mask_ff)) == '0;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("Load while busy.");

    property p_clear_after;
        busy ##1 state_ff == ST_IDLE |-> mask_ff == '0 && !loaded_ff;
    endproperty
    a_clear_after: assert property (p_clear_after) else $error("Latches kept.");

    property p_stray_fault;
        stray_instr |=> fault_ff && !armed_ff;
    endproperty
    a_stray_fault: assert property (p_stray_fault) else $error("No stray fault.");

    property p_reset_latches;
        launch_ok && target_ff == flash_seq_pkg::TGT_CLEAR |-> ##2 mask_ff == '0 && !busy;
    endproperty
    a_reset_latches: assert property (p_reset_latches) else $error("No clear.");

    property p_load_flag;
        state_ff == ST_IDLE && latch_wr |=> loaded_ff && mask_ff != '0;
    endproperty
    a_load_flag: assert property (p_load_flag) else $error("Load unmarked.");

    property p_xmem_redirect;
        xwr && latch_map_ff && xwr_req.pointer_register_form |-> !xmem_wr;
    endproperty
    a_xmem_redirect: assert property (p_xmem_redirect) else $error("Bad redirect.");

endmodule

`default_nettype wire

// ### dv/flash_array_model.sv
// Behavioural flash array that completes the sequencer's byte commands.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    // Clock, reset and command port.
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      flash_req,
    input  wire flash_seq_pkg::flash_cmd_s flash_cmd,
    output logic                           flash_done
);
    flash_seq_pkg::flash_cmd_s last_prog;  // Last program command completed.
    // Answers a held request once, in the cycle after it is seen.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last_prog  <= '0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= flash_req && !flash_done;
            if (flash_req && !flash_done && flash_cmd.op) last_prog <= flash_cmd;
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the flash page programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] CTL = flash_seq_pkg::FLASH_CONTROL_REG_ADDR;  // Control.
    localparam logic [7:0] STA = flash_seq_pkg::FLASH_STATUS_REG_ADDR;   // Status.
    localparam logic [7:0] AUX = flash_seq_pkg::AUX_CONTROL_REG_ADDR;    // Auxiliary control.
    logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, instr_end = 1'b0, xwr = 1'b0;
    logic exec_from_boot = 1'b1, xmem_wr, flash_req, flash_done;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [15:0] code_addr = 16'hff80;  // Extra row base.
    flash_seq_pkg::xdata_wr_s xwr_req = '0;
    flash_seq_pkg::code_src_e code_src;
    flash_seq_pkg::flash_cmd_s flash_cmd;
    int miscompares = 0, n_tests = 0, cyc = 0;
    always #10 clk = ~clk;  // 50 MHz core clock.
    always @(posedge clk) if (++cyc == 4000) conclude(1'b1);  // Hang guard.
    flash_page_program_sequencer dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .instr_end, .exec_from_boot, .xwr, .xwr_req, .xmem_wr, .code_addr,
        .code_src, .flash_req, .flash_cmd, .flash_done);
    flash_array_model model (.clk, .reset, .flash_req, .flash_cmd, .flash_done);
    task automatic conclude(input bit hang);
        miscompares += int'(hang);
        if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        miscompares += int'(got !== exp);
        if (got !== exp) $display("ERROR %s expected %h seen %h", what, exp, got);
    endtask
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        {reg_wr, reg_rd} <= {!rd, rd};
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'h0;
        @(negedge clk);
    endtask
    task automatic st(input logic dp, input logic [15:0] a, input logic [7:0] d, input logic ext);
        @(posedge clk);
        xwr_req <= '{dp, a, d};
        xwr <= 1'b1;
        @(negedge clk) chk("ext write", xmem_wr, ext);
        @(posedge clk);
        xwr <= 1'b0;
    endtask
    task automatic ld(input logic [15:0] a, input logic [7:0] d);
        bus(1'b0, CTL, 8'h0a);  // Latch space on, extra row shown in code space.
        st(1'b1, a, d, 1'b0);
    endtask
    // Arms, launches, tries a pointer-register store while busy, then waits for the walk to end.
    task automatic fire(input logic [3:0] lo);
        bus(1'b0, CTL, {4'h5, lo});
        bus(1'b0, CTL, {4'ha, lo});
        st(1'b1, 16'hff86, 8'h99, !lo[3]);
        for (int i = 0; i < 400 && (i == 0 || reg_rdata[0] === 1'b1); i++) bus(1'b1, CTL, 8'h00);
        chk("done", reg_rdata[0], 1'b0);
    endtask
    task automatic t_more();
        @(posedge clk) code_addr <= flash_seq_pkg::BOOT_BASE;
        bus(1'b0, AUX, 8'h20);
        chk("boot map", code_src, flash_seq_pkg::SRC_BOOT);
        bus(1'b0, AUX, 8'h00);
        chk("boot unmap", code_src, flash_seq_pkg::SRC_USER);
        @(posedge clk) code_addr <= flash_seq_pkg::FUSE_ADDR;
        bus(1'b0, CTL, 8'h04);
        chk("fuse map", code_src, flash_seq_pkg::SRC_FUSE);
        bus(1'b0, CTL, 8'h0c);
        st(1'b0, 16'h0020, 8'h77, 1'b1);
        bus(1'b1, STA, 8'h00);
        chk("indirect", reg_rdata, 8'h00);
        st(1'b1, flash_seq_pkg::FUSE_ADDR, 8'h3c, 1'b0);
        fire(4'h4);
        chk("fuse addr", model.last_prog.addr, flash_seq_pkg::FUSE_ADDR);
        chk("fuse data", model.last_prog.data, 8'h3c);
        ld(16'h0100, 8'h33);
        exec_from_boot <= 1'b0;
        bus(1'b0, CTL, 8'h52);
        bus(1'b0, CTL, 8'ha2);
        @(posedge clk) exec_from_boot <= 1'b1;
        bus(1'b1, CTL, 8'h00);
        chk("no launch", reg_rdata, 8'h02);
        bus(1'b0, CTL, 8'h5a);
        @(posedge clk) instr_end <= 1'b1;  // Arming instruction ends, then a stray one.
        repeat (2) @(posedge clk);
        instr_end <= 1'b0;
        bus(1'b0, CTL, 8'haa);
        bus(1'b1, STA, 8'h00);
        chk("stray", reg_rdata, 8'h03);
        bus(1'b0, CTL, 8'h5a);
        bus(1'b0, CTL, 8'h0a);
        bus(1'b0, CTL, 8'haa);
        bus(1'b1, CTL, 8'h00);
        chk("disarm", reg_rdata, 8'h0a);
        ld(16'hff85, 8'h44);
        fire(4'ha);
        chk("xrow addr", model.last_prog.addr, 16'hff85);
        chk("xrow data", model.last_prog.data, 8'h44);
        bus(1'b1, STA, 8'h00);
        chk("clean", reg_rdata, 8'h00);
    endtask
    task automatic t_program();
        ld(16'h1234, 8'h5a);
        bus(1'b0, CTL, 8'h50);
        bus(1'b0, CTL, 8'ha0);
        bus(1'b1, CTL, 8'h00);
        chk("busy", reg_rdata, 8'h01);
        for (int i = 0; i < 400 && reg_rdata[0] === 1'b1; i++) bus(1'b1, CTL, 8'h00);
        chk("idle", reg_rdata, 8'h00);
        chk("page", model.last_prog.addr, 16'h1234);
    endtask
    task automatic t_keys();
        bus(1'b0, CTL, 8'h50);
        bus(1'b0, CTL, 8'ha0);
        bus(1'b1, STA, 8'h00);
        chk("empty launch", reg_rdata, 8'h02);
        ld(16'h0010, 8'h11);
        chk("xrow map", code_src, flash_seq_pkg::SRC_XROW);
        bus(1'b1, STA, 8'h00);
        chk("loaded", reg_rdata, 8'h03);
        bus(1'b0, CTL, 8'h56);
        bus(1'b0, CTL, 8'ha6);
        repeat (2) @(posedge clk);
        bus(1'b1, STA, 8'h00);
        chk("latch reset", reg_rdata, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_program();
        t_keys();
        t_more();
        conclude(1'b0);
    end
endmodule
`default_nettype wire
